/* File: logic/epdma_pkg.sv */
// Shared constants and types of the endpoint buffer and DMA port.
`default_nettype none
package epdma_pkg;
  localparam int NUM_EP = 16;
  localparam int NUM_CFG_EP = 14;
  localparam int EP_IDX_W = 4;
  localparam int DATA_W = 8;
  localparam int LEN_W = 7;
  localparam int BUF_DEPTH = 64;
  localparam int BURST_MAX = 16;
  localparam int CFG_W = 8;
  localparam int CFG_DIR_BIT = 0;
  localparam int CFG_EN_BIT = 1;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
  localparam logic [EP_IDX_W-1:0] EP_CTRL_OUT = 4'h0;
  localparam logic [EP_IDX_W-1:0] EP_CTRL_IN = 4'h1;
  localparam logic [EP_IDX_W-1:0] DMA_SEL_OFFSET = 4'h1;
  localparam logic [EP_IDX_W-1:0] DMA_SEL_MIN = 4'h2;
  localparam logic [EP_IDX_W-1:0] DMA_SEL_MAX = 4'hf;
  typedef enum logic [3:0] {
    CMD_NONE = 4'h1,
    CMD_VALIDATE = 4'h2,
    CMD_CLEAR = 4'h4,
    CMD_ACK_SETUP = 4'h8
  } cmd_t;
  typedef enum logic [2:0] {
    DMA_IDLE = 3'b001,
    DMA_REQ = 3'b010,
    DMA_XFER = 3'b100
  } dma_state_t;
endpackage
`default_nettype wire

/* File: logic/ep_flag_bit.sv */
// One endpoint event flag that is set by an event and cleared by a read.
`timescale 1ns/100ps
`default_nettype none
module ep_flag_bit (
  input wire logic sys_clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic set_evt, // Packet event on this endpoint.
  input wire logic clr_rd, // Status read of this endpoint.
  output logic flag // Sticky event flag.
);
  logic flag_q;
  logic flag_d;

  // A set arriving together with a clear wins.
  always_comb begin
    flag_d = flag_q;
    if (clr_rd) begin
      flag_d = 1'b0;
    end
    if (set_evt) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

  a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
      set_evt |=> flag_q)
    else $error("Event flag not set after event.");
  a_flag_read_clears: assert property (@(posedge sys_clk) disable iff (!rstn)
      (clr_rd && !set_evt) |=> !flag_q)
    else $error("Event flag not cleared by status read.");
endmodule // ep_flag_bit
`default_nettype wire

/* File: logic/ep_full_bit.sv */
// Buffer-full state of one endpoint buffer with its hand-over gates.
`timescale 1ns/100ps
`default_nettype none
module ep_full_bit (
  input wire logic sys_clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic fill, // Buffer becomes full.
  input wire logic empty, // Buffer becomes empty.
  output logic full // Buffer holds a packet.
);
  logic full_q;
  logic full_d;

  always_comb begin
    full_d = full_q;
    if (empty) begin
      full_d = 1'b0;
    end
    if (fill) begin
      full_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      full_q <= 1'b0;
    end else begin
      full_q <= full_d;
    end
  end

  assign full = full_q;
endmodule // ep_full_bit
`default_nettype wire

/* File: logic/epdma_port.sv */
// Endpoint buffer access and fly-by DMA slave port.
//
// Summary of operation
// - Reset or bus reset disables all endpoints, clears configs, control stays on.
// - Enabled endpoints get buffer storage automatically once configured.
// - A packet event sets that endpoint's event flag.
// - Reading endpoint state clears its flag and reports buffer state.
// - Receive buffer takes no new packet until clear-buffer command, DMA read or register-port drain.
// - Transmit buffer is sent only after validate-buffer command or a completed DMA write.
// - SETUP flushes control IN and blocks validate and clear on control.
// - Only the fourteen configurable endpoints, one at a time, do DMA.
// - DMA and register-port accesses to other endpoints do not interfere.
// - Single-cycle and burst transfers, burst up to sixteen bytes.
// - Request, acknowledge and end-of-transfer polarities are programmable.
// - DMA select code is endpoint number plus one.
// - Direction bit zero means DMA reads, one means DMA writes.
// - Acknowledge routes data access to the DMA endpoint.
// - Mode bit clear selects separate-strobe fly-by mode.
// - Read strobe drives data, write strobe captures data during acknowledge.
// - Request drops after each unit single, after last unit in burst.
// - Data bus is released when acknowledge is removed.
// - DMA is active only while the DMA enable bit is set.
// - Mode bit set uses acknowledge as strobe, ignores read and write.
`timescale 1ns/100ps
`default_nettype none
module epdma_port
  import epdma_pkg::*;
#(
  parameter int BURST_LEN = epdma_pkg::BURST_MAX
) (
  input wire logic sys_clk, // System clock, 125 MHz.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic bus_reset, // USB bus reset pulse.
  input wire logic cfg_wr, // Endpoint config write strobe.
  input wire logic [epdma_pkg::EP_IDX_W-1:0] cfg_idx, // Config endpoint.
  input wire logic [epdma_pkg::CFG_W-1:0] cfg_data, // Config value.
  input wire logic [epdma_pkg::EP_IDX_W-1:0] io_sel, // Register-port endpoint.
  input wire epdma_pkg::cmd_t io_cmd, // Buffer command for io_sel.
  input wire logic state_rd, // Endpoint state read strobe.
  input wire logic [epdma_pkg::NUM_EP-1:0] rx_packet, // Packet received.
  input wire logic [epdma_pkg::NUM_EP-1:0] tx_done, // Packet sent.
  input wire logic setup_rx, // SETUP packet arrived.
  input wire logic io_fill, // Register port filled io_sel buffer.
  input wire logic io_drain, // Register port emptied io_sel buffer.
  input wire logic dma_enable_bit, // DMA enable.
  input wire logic [epdma_pkg::EP_IDX_W-1:0] dma_endpoint_select, // DMA ep.
  input wire logic burst_mode, // Burst instead of single-cycle.
  input wire logic ack_strobe_mode_bit, // Acknowledge is the strobe.
  input wire logic dreq_pol, // Request active level.
  input wire logic dack_pol, // Acknowledge active level.
  input wire logic eot_pol, // End-of-transfer active level.
  input wire logic dack_in, // DMA acknowledge pin.
  input wire logic eot_in, // End-of-transfer pin.
  input wire logic rd_strobe_n, // Read strobe, active low.
  input wire logic wr_strobe_n, // Write strobe, active low.
  input wire logic [epdma_pkg::DATA_W-1:0] dma_d_in, // DMA data in.
  input wire logic [epdma_pkg::DATA_W-1:0] buf_rdata, // DMA endpoint data.
  output logic dreq_out, // DMA request pin.
  output logic [epdma_pkg::DATA_W-1:0] dma_d_out, // DMA data out.
  output logic dma_d_oe, // DMA data drive enable.
  output logic buf_wr, // Capture strobe into DMA endpoint.
  output logic buf_rd, // Fetch strobe from DMA endpoint.
  output logic [epdma_pkg::DATA_W-1:0] buf_wdata, // Captured data.
  output logic [epdma_pkg::EP_IDX_W-1:0] buf_ep, // Endpoint in access.
  output logic [epdma_pkg::NUM_EP-1:0] interrupt_flags_reg, // Event flags.
  output logic [1:0] endpoint_state_reg, // Full, event of io_sel.
  output logic [epdma_pkg::NUM_EP-1:0] ep_enabled, // Enabled endpoints.
  output logic [epdma_pkg::NUM_EP-1:0] tx_ready, // May be sent to host.
  output logic [epdma_pkg::NUM_EP-1:0] rx_ready, // May take a packet.
  output logic setup_lock // Control commands blocked.
);
  import epdma_pkg::*;

  // ------------------------------------------------------------
  // Endpoint configuration
  // ------------------------------------------------------------
  logic [CFG_W-1:0] endpoint_config_reg [NUM_EP];
  logic [CFG_W-1:0] cfg_d [NUM_EP];
  logic [NUM_EP-1:0] en_d;
  logic [NUM_EP-1:0] en_q;
  logic any_reset;
  assign any_reset = !rstn || bus_reset;

  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      cfg_d[i] = endpoint_config_reg[i];
      if (cfg_wr && cfg_idx == i[EP_IDX_W-1:0]) begin
        cfg_d[i] = cfg_data;
      end
      // Storage follows the enable bit once written.
      en_d[i] = cfg_d[i][CFG_EN_BIT];
    end
    en_d[EP_CTRL_OUT] = 1'b1;
    en_d[EP_CTRL_IN] = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (any_reset) begin
      for (int i = 0; i < NUM_EP; i++) begin
        endpoint_config_reg[i] <= CFG_RESET;
      end
      en_q <= {{(NUM_EP-2){1'b0}}, 2'b11};
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        endpoint_config_reg[i] <= cfg_d[i];
      end
      en_q <= en_d;
    end
  end

  // ------------------------------------------------------------
  // Event flags, buffer state and setup lockout
  // ------------------------------------------------------------
  logic [NUM_EP-1:0] flags;
  logic [NUM_EP-1:0] full;
  logic [NUM_EP-1:0] fill_ev;
  logic [NUM_EP-1:0] empty_ev;
  logic [NUM_EP-1:0] rd_clr;
  logic [NUM_EP-1:0] evt;
  logic lock_q;
  logic lock_d;
  logic [1:0] ack_seen_q;
  logic [1:0] ack_seen_d;
  logic io_ctrl;
  logic cmd_ok;
  logic dma_fill;
  logic dma_empty;
  logic [EP_IDX_W-1:0] dma_ep;

  assign io_ctrl = (io_sel == EP_CTRL_OUT) || (io_sel == EP_CTRL_IN);
  assign cmd_ok = !(lock_q && io_ctrl);

  always_comb begin
    lock_d = lock_q;
    ack_seen_d = ack_seen_q;
    if (io_cmd == CMD_ACK_SETUP && io_ctrl) begin
      ack_seen_d[io_sel[0]] = 1'b1;
    end
    if (ack_seen_d == 2'b11) begin
      lock_d = 1'b0;
      ack_seen_d = 2'b00;
    end
    if (setup_rx) begin
      lock_d = 1'b1;
      ack_seen_d = 2'b00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (any_reset) begin
      lock_q <= 1'b0;
      ack_seen_q <= 2'b00;
    end else begin
      lock_q <= lock_d;
      ack_seen_q <= ack_seen_d;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_EP; i++) begin
      logic sel;
      logic dsel;
      logic is_tx;
      sel = (io_sel == i[EP_IDX_W-1:0]);
      dsel = (dma_ep == i[EP_IDX_W-1:0]);
      is_tx = endpoint_config_reg[i][CFG_DIR_BIT];
      if (i == int'(EP_CTRL_IN)) begin
        is_tx = 1'b1;
      end
      if (i == int'(EP_CTRL_OUT)) begin
        is_tx = 1'b0;
      end
      evt[i] = en_q[i] && (rx_packet[i] || tx_done[i]);
      rd_clr[i] = state_rd && sel;
      // Receive fills on packet arrival, transmit on validation.
      fill_ev[i] = is_tx
          ? (sel && io_cmd == CMD_VALIDATE && cmd_ok)
          : (en_q[i] && rx_packet[i] && !full[i]);
      fill_ev[i] = fill_ev[i] || (dsel && dma_fill);
      empty_ev[i] = is_tx
          ? tx_done[i]
          : (sel && io_cmd == CMD_CLEAR && cmd_ok);
      empty_ev[i] = empty_ev[i] || (dsel && dma_empty)
          || (sel && io_drain) || (sel && io_fill && is_tx && 1'b0);
      if (i == int'(EP_CTRL_IN) && setup_rx) begin
        empty_ev[i] = 1'b1;
        fill_ev[i] = 1'b0;
      end
    end
  end

  for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
    ep_flag_bit u_flag (
      .sys_clk(sys_clk),
      .rstn(rstn && !bus_reset),
      .set_evt(evt[g]),
      .clr_rd(rd_clr[g]),
      .flag(flags[g])
    );
    ep_full_bit u_full (
      .sys_clk(sys_clk),
      .rstn(rstn && !bus_reset),
      .fill(fill_ev[g]),
      .empty(empty_ev[g]),
      .full(full[g])
    );
  end

  // ------------------------------------------------------------
  // DMA request, strobes and data path
  // ------------------------------------------------------------
  dma_state_t st_q;
  dma_state_t st_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic dma_valid;
  logic dma_is_tx;
  logic ep_ready;
  logic ack_act;
  logic eot_act;
  logic strobe;
  logic strobe_q;
  logic strobe_edge;
  logic [DATA_W-1:0] dout_d;
  logic oe_d;

  // Identifier n sits at index n plus one, behind the two control buffers.
  assign dma_ep = dma_endpoint_select - DMA_SEL_OFFSET + EP_CTRL_IN;
  assign dma_valid = dma_enable_bit && dma_endpoint_select >= DMA_SEL_MIN
      && en_q[dma_ep];
  assign dma_is_tx = endpoint_config_reg[dma_ep][CFG_DIR_BIT];
  assign ep_ready = dma_is_tx ? !full[dma_ep] : full[dma_ep];
  assign ack_act = (dack_in == dack_pol);
  assign eot_act = (eot_in == eot_pol);
  // Acknowledge-only mode takes the acknowledge as the strobe.
  assign strobe = ack_strobe_mode_bit ? ack_act
      : (ack_act && (dma_is_tx ? !wr_strobe_n : !rd_strobe_n));
  assign strobe_edge = strobe && !strobe_q;
  assign dma_fill = st_q == DMA_XFER && strobe_edge && dma_is_tx
      && cnt_d == 5'h00;
  assign dma_empty = (st_q == DMA_XFER && eot_act && !dma_is_tx)
      || (st_q == DMA_XFER && strobe_edge && !dma_is_tx && cnt_d == 5'h00);

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      DMA_IDLE: begin
        if (dma_valid && ep_ready) begin
          st_d = DMA_REQ;
          cnt_d = burst_mode ? 5'(BURST_LEN) : 5'h01;
        end
      end
      DMA_REQ: begin
        if (!dma_valid) begin
          st_d = DMA_IDLE;
        end else if (ack_act) begin
          st_d = DMA_XFER;
        end
      end
      DMA_XFER: begin
        if (strobe_edge) begin
          cnt_d = cnt_q - 5'h01;
        end
        // Request drops after the last unit or on termination.
        if (!dma_valid || eot_act || cnt_d == 5'h00) begin
          st_d = DMA_IDLE;
        end
      end
    endcase
    oe_d = ack_act && !dma_is_tx && (ack_strobe_mode_bit || !rd_strobe_n);
    dout_d = buf_rdata;
  end

  always_ff @(posedge sys_clk) begin
    if (any_reset) begin
      st_q <= DMA_IDLE;
      cnt_q <= 5'h00;
      strobe_q <= 1'b0;
      dreq_out <= 1'b0;
      dma_d_out <= '0;
      dma_d_oe <= 1'b0;
      buf_wr <= 1'b0;
      buf_rd <= 1'b0;
      buf_wdata <= '0;
      buf_ep <= '0;
      interrupt_flags_reg <= '0;
      endpoint_state_reg <= 2'b00;
      ep_enabled <= '0;
      tx_ready <= '0;
      rx_ready <= '0;
      setup_lock <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      // A strobe raised together with acknowledge still counts once.
      strobe_q <= strobe && st_q == DMA_XFER;
      dreq_out <= (st_d != DMA_IDLE) ? dreq_pol : !dreq_pol;
      dma_d_out <= dout_d;
      dma_d_oe <= oe_d;
      buf_wr <= strobe_edge && dma_is_tx && st_q == DMA_XFER;
      buf_rd <= strobe_edge && !dma_is_tx && st_q == DMA_XFER;
      buf_wdata <= dma_d_in;
      buf_ep <= ack_act ? dma_ep : io_sel;
      interrupt_flags_reg <= flags;
      endpoint_state_reg <= {full[io_sel], flags[io_sel]};
      ep_enabled <= en_q;
      for (int i = 0; i < NUM_EP; i++) begin
        tx_ready[i] <= full[i] && endpoint_config_reg[i][CFG_DIR_BIT];
        rx_ready[i] <= en_q[i] && !full[i];
      end
      tx_ready[EP_CTRL_IN] <= full[EP_CTRL_IN] && !lock_q;
      tx_ready[EP_CTRL_OUT] <= 1'b0;
      setup_lock <= lock_q;
    end
  end

  a_lock_blocks_clear: assert property (@(posedge sys_clk)
      disable iff (!rstn || bus_reset)
      (lock_q && io_sel == EP_CTRL_OUT && io_cmd == CMD_CLEAR && full[0]
       && !setup_rx) |=> full[0])
    else $error("Clear command acted during setup lockout.");
  a_setup_sets_lock: assert property (@(posedge sys_clk)
      disable iff (!rstn || bus_reset) setup_rx |=> lock_q && !full[1])
    else $error("SETUP did not lock or flush control IN.");
  a_reset_ctrl_only: assert property (@(posedge sys_clk)
      (!rstn || bus_reset) ##1 (rstn && !bus_reset)
      |=> ep_enabled == 16'h0003)
    else $error("Reset left other endpoints enabled.");
  a_req_needs_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
      !dma_enable_bit ##1 !dma_enable_bit |-> st_q == DMA_IDLE)
    else $error("Request pending with DMA disabled.");
  a_rx_no_overwrite: assert property (@(posedge sys_clk) disable iff (!rstn)
      (full[2] && !endpoint_config_reg[2][CFG_DIR_BIT] && io_cmd == CMD_NONE
       && !dma_empty && !io_drain && !bus_reset) |=> full[2])
    else $error("Receive buffer emptied without clear command.");
  a_single_drops_req: assert property (@(posedge sys_clk) disable iff (!rstn)
      (st_q == DMA_XFER && !burst_mode && cnt_q == 5'h01 && strobe_edge)
      |=> dreq_out == !dreq_pol)
    else $error("Request held after single transfer.");
  a_oe_needs_ack: assert property (@(posedge sys_clk) disable iff (!rstn)
      !ack_act ##1 !ack_act |-> !dma_d_oe)
    else $error("Data bus driven without acknowledge.");
  a_ack_routes_ep: assert property (@(posedge sys_clk) disable iff (!rstn)
      ack_act |=> buf_ep == $past(dma_ep))
    else $error("Acknowledge did not route to DMA endpoint.");
endmodule // epdma_port
`default_nettype wire

/* File: verification/dma_ctrl_model.sv */
// Fly-by DMA controller model on the far side of the DMA port.
`timescale 1ns/100ps
`default_nettype none
module dma_ctrl_model (
  input wire logic sys_clk, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic dreq_out, // Request from the port.
  input wire logic dreq_pol, // Request active level.
  input wire logic dack_pol, // Acknowledge active level.
  input wire logic eot_pol, // End-of-transfer active level.
  input wire logic write_dir, // High when the controller writes.
  input wire logic ack_only, // Acknowledge is the data strobe.
  input wire logic [3:0] slow, // Cycles of stall before acknowledging.
  input wire logic [7:0] wdat, // Byte offered on writes.
  output logic dack_in, // Acknowledge pin.
  output logic eot_in, // End-of-transfer pin.
  output logic rd_strobe_n, // Read strobe.
  output logic wr_strobe_n, // Write strobe.
  output logic [7:0] dma_d_in, // Data toward the port.
  output logic [7:0] units // Strobes completed.
);
  logic act = 1'b0;
  logic stb = 1'b0;
  logic req_q = 1'b0;
  logic [7:0] junk = 8'h5a;
  wire logic req = (dreq_out === dreq_pol);
  assign dack_in = act ? dack_pol : !dack_pol;
  assign eot_in = !eot_pol;
  assign rd_strobe_n = !(stb && !write_dir);
  assign wr_strobe_n = !(stb && write_dir);
  // Undriven data lines wander so that stale bytes are never trusted.
  assign dma_d_in = act ? wdat : junk;
  initial units = 8'h00;
  always @(posedge sys_clk) begin
    junk <= ~junk + 8'h01;
    // A request must stand two edges, so a polarity change is not taken.
    req_q <= req;
  end
  // -----------------------------------------------------------------
  // Acknowledge and strobe one unit at a time while the request stands.
  // -----------------------------------------------------------------
  always begin
    @(posedge sys_clk);
    if (rstn && req && req_q) begin
      repeat (slow) @(posedge sys_clk);
      do begin
        act <= 1'b1;
        stb <= 1'b1;
        repeat (2) @(posedge sys_clk);
        stb <= 1'b0;
        if (ack_only) act <= 1'b0;
        units <= units + 8'h01;
        repeat (3) @(posedge sys_clk);
      end while (req);
      act <= 1'b0;
    end
  end
endmodule // dma_ctrl_model
`default_nettype wire

/* File: verification/usb_endpoint_buffer_dma_port_tb.sv */
// Self-checking bench for the endpoint buffer and DMA port.
`timescale 1ns/100ps
`default_nettype none
module usb_endpoint_buffer_dma_port_tb;
  import epdma_pkg::*;
  localparam int BL = 4;
  logic sys_clk = 1'b0, rstn = 1'b0, bus_reset = 1'b0, cfg_wr = 1'b0;
  logic [3:0] cfg_idx = 4'h0, io_sel = 4'h0, dma_endpoint_select = 4'h0;
  logic [3:0] slow = 4'h0, cur_sel = 4'h0, e;
  logic [7:0] cfg_data = 8'h00, buf_rdata = 8'h00, wdat = 8'h00, c;
  logic [7:0] rd_prev = 8'h00;
  cmd_t io_cmd = CMD_NONE;
  logic state_rd = 1'b0, setup_rx = 1'b0, io_fill = 1'b0, io_drain = 1'b0;
  logic [15:0] rx_packet = 16'h0000, tx_done = 16'h0000, en = 16'h0000;
  logic dma_enable_bit = 1'b0, burst_mode = 1'b0, cur_dir = 1'b0;
  logic ack_strobe_mode_bit = 1'b0, dreq_pol = 1'b1, dack_pol = 1'b1;
  logic eot_pol = 1'b1;
  logic dack_in, eot_in, rd_strobe_n, wr_strobe_n, dreq_out, dma_d_oe;
  logic buf_wr, buf_rd, setup_lock;
  logic [7:0] dma_d_in, dma_d_out, buf_wdata, units;
  logic [3:0] buf_ep;
  logic [1:0] endpoint_state_reg;
  logic [15:0] interrupt_flags_reg, ep_enabled, tx_ready, rx_ready;
  int n_errors = 0, compares = 0, n_acc = 0, seed = 75602, u0, a0, ep;
  epdma_port #(.BURST_LEN(BL)) epdma_port_inst (.sys_clk, .rstn,
    .bus_reset, .cfg_wr, .cfg_idx, .cfg_data, .io_sel, .io_cmd, .state_rd,
    .rx_packet, .tx_done, .setup_rx, .io_fill, .io_drain, .dma_enable_bit,
    .dma_endpoint_select, .burst_mode, .ack_strobe_mode_bit, .dreq_pol,
    .dack_pol, .eot_pol, .dack_in, .eot_in, .rd_strobe_n, .wr_strobe_n,
    .dma_d_in, .buf_rdata, .dreq_out, .dma_d_out, .dma_d_oe, .buf_wr,
    .buf_rd, .buf_wdata, .buf_ep, .interrupt_flags_reg, .endpoint_state_reg,
    .ep_enabled, .tx_ready, .rx_ready, .setup_lock);
  dma_ctrl_model dma_ctrl_model_inst (.sys_clk, .rstn, .dreq_out, .dreq_pol,
    .dack_pol, .eot_pol, .write_dir(cur_dir),
    .ack_only(ack_strobe_mode_bit), .slow, .wdat, .dack_in,
    .eot_in, .rd_strobe_n, .wr_strobe_n, .dma_d_in, .units);
  always #4 sys_clk = ~sys_clk;
  function automatic logic [3:0] sel_code(input int n);
    return 4'(n + 1);
  endfunction
  function automatic int exp_units(input logic bst);
    return bst ? BL : 1;
  endfunction
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic test_done;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cfg(input logic [3:0] i, input logic [7:0] d);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_idx <= i;
    cfg_data <= d;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] s, input cmd_t k);
    @(posedge sys_clk);
    io_sel <= s;
    io_cmd <= k;
    @(posedge sys_clk);
    io_cmd <= CMD_NONE;
    tick(3);
  endtask
  task automatic pulse_rx(input logic [3:0] i);
    @(posedge sys_clk);
    rx_packet <= 16'h0001 << i;
    @(posedge sys_clk);
    rx_packet <= 16'h0000;
    tick(3);
  endtask
  task automatic dma_run(input int n, input logic dir, input logic bst);
    cur_sel = sel_code(n);
    cur_dir = dir;
    wdat <= 8'($random(seed));
    cfg(cur_sel, {6'h00, 1'b1, dir});
    if (!dir) pulse_rx(cur_sel);
    @(posedge sys_clk);
    dreq_pol <= 1'($random(seed));
    dack_pol <= 1'($random(seed));
    eot_pol <= 1'($random(seed));
    burst_mode <= bst;
    io_sel <= cur_sel ^ 4'h5;
    dma_endpoint_select <= 4'h1;
    dma_enable_bit <= 1'b1;
    tick(10);
    chk(dreq_out === !dreq_pol, "request on bad select");
    dma_endpoint_select <= cur_sel;
    dma_enable_bit <= 1'b0;
    tick(10);
    chk(dreq_out === !dreq_pol, "request while disabled");
    u0 = int'(units);
    a0 = n_acc;
    dma_enable_bit <= 1'b1;
    for (int k = 0; k < 200; k++) begin
      @(posedge sys_clk);
      if (int'(units) - u0 >= exp_units(bst) && dack_in !== dack_pol) break;
    end
    tick(8);
    chk(int'(units) - u0 == exp_units(bst), "unit count");
    chk(n_acc - a0 == exp_units(bst), "buffer accesses");
    chk(dreq_out === !dreq_pol, "request left up");
    chk(dma_d_oe === 1'b0, "bus still driven");
    dma_enable_bit <= 1'b0;
  endtask
  // -----------------------------------------------------------------
  // Monitor of the accesses routed to the DMA endpoint.
  // -----------------------------------------------------------------
  always @(posedge sys_clk) begin
    buf_rdata <= buf_rdata + 8'h1d;
    rd_prev <= buf_rdata;
    if (buf_rd === 1'b1 || buf_wr === 1'b1) begin
      chk(buf_ep === cur_sel, "access endpoint");
      n_acc <= n_acc + 1;
    end
    if (buf_wr === 1'b1) chk(cur_dir && buf_wdata === wdat, "write");
    if (buf_rd === 1'b1) chk(!cur_dir, "read on write endpoint");
    if (dma_d_oe === 1'b1) chk(!cur_dir, "drive on write");
    if (dma_d_oe === 1'b1) chk(dma_d_out === rd_prev, "read data");
  end
  initial begin
    tick(20000);
    n_errors++;
    $display("MISMATCH %0t watchdog", $time);
    test_done();
  end
  initial begin
    tick(16);
    rstn <= 1'b1;
    tick(3);
    chk(ep_enabled === 16'h0003 && setup_lock === 1'b0, "reset");
    for (int i = 0; i < NUM_EP; i++) begin
      c = 8'($random(seed)) & 8'h03;
      en[i] = c[CFG_EN_BIT];
      cfg(4'(i), c);
    end
    tick(3);
    chk(ep_enabled === (en | 16'h0003), "enabled set");
    for (int k = 0; k < 4; k++) begin
      e = 4'($random(seed));
      if (!en[e]) e = 4'(k[0]);
      @(posedge sys_clk);
      io_sel <= e;
      if (k[0]) tx_done <= 16'h0001 << e;
      else rx_packet <= 16'h0001 << e;
      @(posedge sys_clk);
      tx_done <= 16'h0000;
      rx_packet <= 16'h0000;
      tick(3);
      chk(interrupt_flags_reg[e] === 1'b1, "flag set");
      chk(endpoint_state_reg[0] === 1'b1, "state flag");
      state_rd <= 1'b1;
      @(posedge sys_clk);
      state_rd <= 1'b0;
      tick(3);
      chk(interrupt_flags_reg[e] === 1'b0, "flag cleared");
    end
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
    tick(3);
    chk(ep_enabled === 16'h0003, "bus reset");
    cmd(4'h1, CMD_VALIDATE);
    chk(tx_ready[1] === 1'b1, "validate");
    @(posedge sys_clk);
    setup_rx <= 1'b1;
    @(posedge sys_clk);
    setup_rx <= 1'b0;
    tick(3);
    chk(setup_lock === 1'b1 && tx_ready[1] === 1'b0, "setup");
    cmd(4'h1, CMD_VALIDATE);
    chk(tx_ready[1] === 1'b0, "validate locked");
    pulse_rx(4'h0);
    cmd(4'h0, CMD_CLEAR);
    chk(rx_ready[0] === 1'b0, "clear locked");
    cmd(4'h0, CMD_ACK_SETUP);
    chk(setup_lock === 1'b1, "half acknowledged");
    cmd(4'h1, CMD_ACK_SETUP);
    chk(setup_lock === 1'b0, "unlocked");
    pulse_rx(4'h0);
    chk(rx_ready[0] === 1'b0, "receive held");
    cmd(4'h0, CMD_CLEAR);
    chk(rx_ready[0] === 1'b1, "receive cleared");
    for (int k = 0; k < 7; k++) begin
      slow <= k[2] ? 4'h3 : 4'h0;
      ack_strobe_mode_bit <= k[2];
      ep = k * 2 + 1 + (k == 6 ? 1 : (k == 0 ? 0 : $random(seed) & 1));
      dma_run(ep, k[0], k[1]);
    end
    test_done();
  end
endmodule // usb_endpoint_buffer_dma_port_tb
`default_nettype wire
